//--- cms_pkg.sv
// Overview of operation
// - control bit 0 lets the reference-failure flag raise the timing service output
// - control bit 1 lets either transmit slip flag raise the timing service output
// - control bit 3 lets either receive slip flag raise the timing service output
// - control bit 5 lets the timing-loss flag raise the timing service output
// - control bit 6 lets the out-of-sync flag raise the timing service output
// - writing one to control bit 2 snapshots live counts; stored level ignored
// - control bit 7 enables the timing-cell receive circuit
// - control bits 15:8 always read zero
// - status bit 0 latches reference failure; free-run follows it when field is 01
// - status flags 6:0 clear only by writing one; zero leaves them
// - status bit 1 latches transmit slip underrun
// - status bit 2 latches transmit slip overrun
// - status bits 3 and 4 latch receive slip underrun and overrun
// - status bit 5 latches timing loss only while timing-cell receive is enabled
// - status bit 6 sets only on entry into out-of-sync
// - status bit 15 is the OR of bits 6:0; bits 14:7 read zero
// - test force makes status bits 6:0 all read one
// - two-bit select picks divider, recovered clock, secondary or external reference
// - configuration bit 2 picks master or double-rate clock for the divider
// - bit 3 squares external input: rise gives output fall, other edge near half
// - bit 4 squares the secondary input, otherwise it passes unchanged
// - squared secondary input: rise passes as rise, fall placed at half duty
// - free-run field: 00 high, 01 follows failure flag, 1x low
package cms_pkg;
	// register offsets
	localparam logic [15:0] ADDR_CTRL = 16'h6080;
	localparam logic [15:0] ADDR_STAT = 16'h6082;
	localparam logic [15:0] ADDR_MCG = 16'h6090;
	localparam logic [15:0] ADDR_CNT0 = 16'h60a2;
	localparam logic [15:0] ADDR_CNT1 = 16'h60a4;
	localparam logic [15:0] ADDR_CNT2 = 16'h60a6;
	// control fields
	localparam int CTRL_REF_FAIL_IE = 0;
	localparam int CTRL_TX_IE = 1;
	localparam int CTRL_SNAPSHOT = 2;
	localparam int CTRL_RX_IE = 3;
	localparam int CTRL_LOSS_IE = 5;
	localparam int CTRL_SYNC_IE = 6;
	localparam int CTRL_TIM_EN = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// status fields
	localparam int ST_REF_FAIL = 0;
	localparam int ST_TX_UND = 1;
	localparam int ST_TX_OVR = 2;
	localparam int ST_RX_UND = 3;
	localparam int ST_RX_OVR = 4;
	localparam int ST_LOSS = 5;
	localparam int ST_SYNC = 6;
	localparam logic [6:0] STAT_RESET = 7'h00;
	// master clock generation fields
	localparam int MCG_REF_SOURCE_SELECT_LSB = 0;
	localparam int MCG_DIV_SRC = 2;
	localparam int MCG_EXT_SQ = 3;
	localparam int MCG_SEC_SQ = 4;
	localparam int MCG_FREE_RUN_OUTPUT_LSB = 11;
	localparam logic [12:0] MCG_RESET = 13'h00c0;
	// reference select and free-run codes
	typedef enum logic [1:0] {
		REF_DIVIDER = 2'h0,
		REF_RECOVERED = 2'h1,
		REF_SECONDARY = 2'h2,
		REF_EXTERNAL = 2'h3
	} cms_ref_sel_t;
	localparam logic [1:0] FR_ALWAYS_ON = 2'h0;
	localparam logic [1:0] FR_FOLLOW_FAIL = 2'h1;
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int REF_FAIL_TIME_NS = 250000;
	localparam int REF_FAIL_CYCLES = REF_FAIL_TIME_NS / CLK_PERIOD_NS;
	localparam int SQ_CNT_W = 15;
	localparam int DIV_CNT_W = 15;
endpackage

//--- cms_sq_if.sv
`timescale 1ns/100ps
// raw pulse in, squared wave out
interface cms_sq_if;
	logic pulseIn;
	logic squareOut;
	modport squarer (input pulseIn, output squareOut);
	modport user (output pulseIn, input squareOut);
endinterface

//--- cms_squarer.sv
`timescale 1ns/100ps
module cms_squarer
	import cms_pkg::*;
#(
	parameter bit INVERT = 1'b0
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// pulse in, square out
	cms_sq_if.squarer sq
);
	logic prevIn, next_prevIn;
	logic outLvl, next_outLvl;
	logic [SQ_CNT_W-1:0] periodCnt, next_periodCnt;
	logic [SQ_CNT_W-1:0] halfPoint, next_halfPoint;
	logic rise;

	// rising edge restarts the period; the opposite edge lands on the last half period,
	// so it carries up to one clock of jitter while the rising edge carries none
	always_comb
	begin
		rise = sq.pulseIn & ~prevIn;
		next_prevIn = sq.pulseIn;
		next_periodCnt = periodCnt;
		next_halfPoint = halfPoint;
		next_outLvl = outLvl;
		if (rise)
		begin
			next_periodCnt = {{(SQ_CNT_W-1){1'b0}}, 1'b1};
			next_halfPoint = periodCnt >> 1;
			next_outLvl = ~INVERT;
		end
		else
		begin
			if (periodCnt != {SQ_CNT_W{1'b1}})
				next_periodCnt = periodCnt + 1'b1; // saturate, input stuck
			if (periodCnt == halfPoint)
				next_outLvl = INVERT;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			prevIn <= 1'b0;
			outLvl <= 1'b0;
			periodCnt <= '0;
			halfPoint <= '0;
		end
		else
		begin
			prevIn <= next_prevIn;
			outLvl <= next_outLvl;
			periodCnt <= next_periodCnt;
			halfPoint <= next_halfPoint;
		end
	end

	assign sq.squareOut = outLvl;
endmodule

//--- cms_divider.sv
`timescale 1ns/100ps
module cms_divider
	import cms_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// source ticks and ratio
	input wire logic srcTick,
	input wire logic [13:0] divValue,
	// divided reference
	output logic divOut
);
	logic [DIV_CNT_W-1:0] cnt, next_cnt;
	logic [DIV_CNT_W-1:0] ratio;
	logic next_divOut;

	// divide by value plus two; high for the first half of each cycle
	always_comb
	begin
		ratio = {1'b0, divValue} + 15'h0002;
		next_cnt = cnt;
		if (srcTick)
			next_cnt = (cnt >= ratio - 15'h0001) ? '0 : cnt + 1'b1;
		next_divOut = next_cnt < (ratio >> 1);
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			cnt <= '0;
			divOut <= 1'b0;
		end
		else
		begin
			cnt <= next_cnt;
			divOut <= next_divOut;
		end
	end
endmodule

//--- cms_clock_module.sv
`timescale 1ns/100ps
module cms_clock_module
	import cms_pkg::*;
#(
	parameter int REF_FAIL_LIMIT = REF_FAIL_CYCLES
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// register port
	input wire logic [15:0] regAddr,
	input wire logic regWrEn,
	input wire logic [15:0] regWrData,
	input wire logic regRdEn,
	output logic [15:0] regRdData,
	// events from neighbouring logic, same clock
	input wire logic tsTxUnderrun,
	input wire logic tsTxOverrun,
	input wire logic tsRxUnderrun,
	input wire logic tsRxOverrun,
	input wire logic timingLossEvent,
	input wire logic syncLost,
	input wire logic flagTestForce,
	// live counts and divider ratio
	input wire logic [2:0][15:0] liveCount,
	input wire logic [13:0] dividerValue,
	// reference pins, asynchronous
	input wire logic secondary8kPin,
	input wire logic external8kPin,
	input wire logic recoveredCircuitClock,
	input wire logic doubleRateClockIn,
	// outputs
	output logic ref8kClock,
	output logic freeRunOutput,
	output logic chipTimingService,
	output logic timingCellRxEn,
	output logic countSnapshotStrobe,
	output logic [2:0][15:0] heldCount
);
	localparam int WW = $clog2(REF_FAIL_LIMIT + 1);

	// register and state storage
	logic [7:0] ctrl, next_ctrl;
	logic [6:0] flags, next_flags;
	logic [12:0] mcg, next_mcg;
	logic [3:0] sync1, sync2;
	logic [3:0] next_sync1, next_sync2;
	logic prevDbl, next_prevDbl;
	logic prevRef, next_prevRef;
	logic prevSync, next_prevSync;
	logic [WW-1:0] watchCnt, next_watchCnt;
	logic next_ref8kClock, next_freeRunOutput, next_service;
	logic next_snapshot;
	logic [2:0][15:0] next_heldCount;
	logic [15:0] next_regRdData;
	logic [6:0] setEv, clrMask, statView;
	logic failEvent, refRise, dblRise;
	logic divOut;
	cms_ref_sel_t ref_source_select;

	cms_sq_if extSq ();
	cms_sq_if secSq ();

	// true when a register write hits the given offset
	function automatic logic hit(input logic [15:0] addr, input logic [15:0] off);
		hit = (addr == off);
	endfunction

	// two-flop synchronisers for the pins
	always_comb
	begin
		next_sync1 = {doubleRateClockIn, recoveredCircuitClock, external8kPin,
			secondary8kPin};
		next_sync2 = sync1;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
		end
		else
		begin
			sync1 <= next_sync1;
			sync2 <= next_sync2;
		end
	end

	// squarers; external is inverted, secondary keeps polarity
	assign extSq.pulseIn = sync2[1];
	assign secSq.pulseIn = sync2[0];

	cms_squarer #(.INVERT(1'b1)) extSquarer (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.sq(extSq.squarer)
	);

	cms_squarer #(.INVERT(1'b0)) secSquarer (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.sq(secSq.squarer)
	);

	// divider runs on every master clock or on synchronised double-rate edges;
	// the double-rate clock is sampled, so it must stay well below half the master rate
	always_comb
	begin
		dblRise = sync2[3] & ~prevDbl;
		next_prevDbl = sync2[3];
	end

	cms_divider divider (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.srcTick(mcg[MCG_DIV_SRC] ? dblRise : 1'b1),
		.divValue(dividerValue),
		.divOut(divOut)
	);

	// control register, write only stores the low byte
	always_comb
	begin
		next_ctrl = ctrl;
		if (regWrEn && hit(regAddr, ADDR_CTRL))
			next_ctrl = regWrData[7:0]; // upper byte dropped
		next_mcg = mcg;
		if (regWrEn && hit(regAddr, ADDR_MCG))
			next_mcg = regWrData[12:0];
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			ctrl <= CTRL_RESET;
			mcg <= MCG_RESET;
		end
		else
		begin
			ctrl <= next_ctrl;
			mcg <= next_mcg;
		end
	end

	// count snapshot fires on each write of one, whatever was stored before
	always_comb
	begin
		next_snapshot = regWrEn && hit(regAddr, ADDR_CTRL)
			&& regWrData[CTRL_SNAPSHOT];
		next_heldCount = heldCount;
		if (next_snapshot)
			next_heldCount = liveCount;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			countSnapshotStrobe <= 1'b0;
			heldCount <= '0;
		end
		else
		begin
			countSnapshotStrobe <= next_snapshot;
			heldCount <= next_heldCount;
		end
	end

	assign timingCellRxEn = ctrl[CTRL_TIM_EN];

	// reference select mux with optional squaring
	always_comb
	begin
		ref_source_select = cms_ref_sel_t'(mcg[MCG_REF_SOURCE_SELECT_LSB +: 2]);
		case (ref_source_select)
			REF_DIVIDER: next_ref8kClock = divOut;
			REF_RECOVERED: next_ref8kClock = sync2[2];
			REF_SECONDARY: next_ref8kClock = mcg[MCG_SEC_SQ] ? secSq.squareOut
				: sync2[0];
			REF_EXTERNAL: next_ref8kClock = mcg[MCG_EXT_SQ] ? extSq.squareOut
				: sync2[1];
			default: next_ref8kClock = divOut;
		endcase
	end

	// failure watchdog: no rising reference edge within the limit;
	// it saturates so one outage gives one event, not a stream
	always_comb
	begin
		refRise = ref8kClock & ~prevRef;
		next_prevRef = ref8kClock;
		next_prevSync = syncLost;
		failEvent = 1'b0;
		next_watchCnt = watchCnt;
		if (refRise)
			next_watchCnt = '0;
		else if (watchCnt != WW'(REF_FAIL_LIMIT))
		begin
			next_watchCnt = watchCnt + 1'b1;
			failEvent = (watchCnt == WW'(REF_FAIL_LIMIT - 1));
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			ref8kClock <= 1'b0;
			prevRef <= 1'b0;
			prevDbl <= 1'b0;
			prevSync <= 1'b0;
			watchCnt <= '0;
		end
		else
		begin
			ref8kClock <= next_ref8kClock;
			prevRef <= next_prevRef;
			prevDbl <= next_prevDbl;
			prevSync <= next_prevSync;
			watchCnt <= next_watchCnt;
		end
	end

	// sticky status flags; a set in the clearing cycle survives
	always_comb
	begin
		setEv = '0;
		setEv[ST_REF_FAIL] = failEvent;
		setEv[ST_TX_UND] = tsTxUnderrun;
		setEv[ST_TX_OVR] = tsTxOverrun;
		setEv[ST_RX_UND] = tsRxUnderrun;
		setEv[ST_RX_OVR] = tsRxOverrun;
		setEv[ST_LOSS] = timingLossEvent & ctrl[CTRL_TIM_EN];
		setEv[ST_SYNC] = syncLost & ~prevSync; // entry only
		clrMask = '0;
		if (regWrEn && hit(regAddr, ADDR_STAT))
			clrMask = regWrData[6:0]; // ones clear, zeros
		next_flags = (flags & ~clrMask) | setEv;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			flags <= STAT_RESET;
		else
			flags <= next_flags;
	end

	// test force overrides the visible flags, the stored ones are untouched
	assign statView = flags | {7{flagTestForce}};

	// service summary and free-run pin
	always_comb
	begin
		next_service = (ctrl[CTRL_REF_FAIL_IE] & statView[ST_REF_FAIL])
			| (ctrl[CTRL_TX_IE] & (statView[ST_TX_UND] | statView[ST_TX_OVR]))
			| (ctrl[CTRL_RX_IE] & (statView[ST_RX_UND] | statView[ST_RX_OVR]))
			| (ctrl[CTRL_LOSS_IE] & statView[ST_LOSS])
			| (ctrl[CTRL_SYNC_IE] & statView[ST_SYNC]);
		case (mcg[MCG_FREE_RUN_OUTPUT_LSB +: 2])
			FR_ALWAYS_ON: next_freeRunOutput = 1'b1;
			FR_FOLLOW_FAIL: next_freeRunOutput = flags[ST_REF_FAIL];
			default: next_freeRunOutput = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			chipTimingService <= 1'b0;
			freeRunOutput <= 1'b1;
		end
		else
		begin
			chipTimingService <= next_service;
			freeRunOutput <= next_freeRunOutput;
		end
	end

	// read data, registered; unmapped offsets read zero
	always_comb
	begin
		next_regRdData = regRdData;
		if (regRdEn)
		begin
			case (regAddr)
				ADDR_CTRL: next_regRdData = {8'h00, ctrl};
				ADDR_STAT: next_regRdData = {|statView, 8'h00, statView};
				ADDR_MCG: next_regRdData = {3'h0, mcg};
				ADDR_CNT0: next_regRdData = heldCount[0];
				ADDR_CNT1: next_regRdData = heldCount[1];
				ADDR_CNT2: next_regRdData = heldCount[2];
				default: next_regRdData = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			regRdData <= 16'h0000;
		else
			regRdData <= next_regRdData;
	end
endmodule

//--- cms_clock_props.sv
`timescale 1ns/100ps
module cms_clock_props
	import cms_pkg::*;
#(
	parameter int REF_FAIL_LIMIT = REF_FAIL_CYCLES
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// register port
	input wire logic [15:0] regAddr,
	input wire logic regWrEn,
	input wire logic [15:0] regWrData,
	input wire logic regRdEn,
	input wire logic [15:0] regRdData,
	// events
	input wire logic tsTxUnderrun, tsTxOverrun, tsRxUnderrun, tsRxOverrun,
	input wire logic timingLossEvent, syncLost,
	// counts and outputs
	input wire logic [2:0][15:0] liveCount,
	input wire logic [2:0][15:0] heldCount,
	input wire logic freeRunOutput, chipTimingService, timingCellRxEn, countSnapshotStrobe
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	logic [7:0] ctrl;
	logic [1:0] free_run_output;
	// shadow of enables and free-run field, so the checks know the mode
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			ctrl <= 8'h00;
			free_run_output <= 2'h0;
		end
		else if (regWrEn && regAddr == ADDR_CTRL)
			ctrl <= regWrData[7:0];
		else if (regWrEn && regAddr == ADDR_MCG)
			free_run_output <= regWrData[12:11];
	end
	// no write at the event edge or the next, so the enables cannot move
	sequence s_quiet;
		!regWrEn ##1 !regWrEn;
	endsequence
	sequence s_read(a);
		regRdEn && regAddr == a;
	endsequence
	chk_ctrl_upper_zero: assert property (s_read(ADDR_CTRL) |=> regRdData[15:8] == 8'h00)
		else $error("control upper byte set");
	chk_status_layout: assert property (s_read(ADDR_STAT) |=> regRdData[14:7] == 8'h00
		&& regRdData[15] == (|regRdData[6:0])) else $error("status summary wrong");
	chk_snap_pulse: assert property (regWrEn && regAddr == ADDR_CTRL && regWrData[2]
		|=> countSnapshotStrobe && heldCount == $past(liveCount)) else $error("snapshot missed");
	chk_snap_idle: assert property (!(regWrEn && regAddr == ADDR_CTRL && regWrData[2])
		|=> !countSnapshotStrobe && $stable(heldCount)) else $error("stray snapshot");
	chk_rx_enable: assert property (timingCellRxEn == ctrl[CTRL_TIM_EN])
		else $error("receive enable wrong");
	chk_tx_service: assert property ((tsTxUnderrun || tsTxOverrun) && ctrl[1] ##0 s_quiet
		|=> chipTimingService) else $error("transmit slip not served");
	chk_rx_service: assert property ((tsRxUnderrun || tsRxOverrun) && ctrl[3] ##0 s_quiet
		|=> chipTimingService) else $error("receive slip not served");
	chk_loss_service: assert property (timingLossEvent && ctrl[5] && ctrl[7] ##0 s_quiet
		|=> chipTimingService) else $error("timing loss not served");
	chk_sync_service: assert property ($rose(syncLost) && ctrl[6] ##0 s_quiet
		|=> chipTimingService) else $error("sync loss not served");
	chk_free_high: assert property (free_run_output == FR_ALWAYS_ON |=> freeRunOutput)
		else $error("free-run not high");
	chk_free_low: assert property (free_run_output[1] |=> !freeRunOutput)
		else $error("free-run not low");
endmodule
bind cms_clock_module cms_clock_props #(.REF_FAIL_LIMIT(REF_FAIL_LIMIT)) u_props (
	.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrEn(regWrEn),
	.regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
	.tsTxUnderrun(tsTxUnderrun), .tsTxOverrun(tsTxOverrun), .tsRxUnderrun(tsRxUnderrun),
	.tsRxOverrun(tsRxOverrun), .timingLossEvent(timingLossEvent), .syncLost(syncLost),
	.liveCount(liveCount), .heldCount(heldCount), .freeRunOutput(freeRunOutput),
	.chipTimingService(chipTimingService), .timingCellRxEn(timingCellRxEn),
	.countSnapshotStrobe(countSnapshotStrobe)
);

//--- tb_top.sv
`timescale 1ns/100ps
module tb_top;
	import cms_pkg::*;
	localparam int LIMIT = 64;
	localparam int SQ_PERIOD = 20;
	logic core_clk, rst_n = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0, flagTestForce = 1'b0;
	logic [15:0] regAddr = 16'h0000, regWrData = 16'h0000, regRdData, d;
	logic [5:0] evt = 6'h00;
	logic [3:0] pins = 4'h0; // double rate, recovered, secondary, external
	logic [2:0][15:0] liveCount = '0, heldCount, snap;
	logic ref8kClock, freeRunOutput, chipTimingService, timingCellRxEn, countSnapshotStrobe;
	int seed = 32'hacc1, bad_count = 0, checks_done = 0, cycles = 0;
	int refPeriod;
	// divider ratio starts at eight so the reference stays alive until it is retuned
	logic [13:0] divVal = 14'h0006;
	cms_clock_module #(.REF_FAIL_LIMIT(LIMIT)) u_dut (
		.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrEn(regWrEn),
		.regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
		.tsTxUnderrun(evt[0]), .tsTxOverrun(evt[1]), .tsRxUnderrun(evt[2]),
		.tsRxOverrun(evt[3]), .timingLossEvent(evt[4]), .syncLost(evt[5]),
		.flagTestForce(flagTestForce), .liveCount(liveCount), .dividerValue(divVal),
		.secondary8kPin(pins[2]), .external8kPin(pins[3]), .recoveredCircuitClock(pins[1]),
		.doubleRateClockIn(pins[0]), .ref8kClock(ref8kClock), .freeRunOutput(freeRunOutput),
		.chipTimingService(chipTimingService), .timingCellRxEn(timingCellRxEn),
		.countSnapshotStrobe(countSnapshotStrobe), .heldCount(heldCount)
	);
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] v);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= v;
		regWrEn <= 1'b1;
		@(posedge core_clk);
		regWrEn <= 1'b0;
		#1;
	endtask
	// data is sampled a full cycle late; it holds until the next read
	task automatic rdchk(input string n, input logic [15:0] a, input logic [15:0] e);
		@(posedge core_clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge core_clk);
		regRdEn <= 1'b0;
		@(posedge core_clk);
		#1 chk(n, e, regRdData);
	endtask
	// out-of-sync is a level, so it stays up after the pulse
	task automatic pulse(input logic [5:0] v);
		@(posedge core_clk);
		evt <= v;
		@(posedge core_clk);
		evt <= v & 6'h20;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// cycles between two rising reference edges; with dbl the double-rate pin
	// toggles every second cycle, so the divider sees one tick per four cycles
	task automatic ref_period(input logic dbl, output int p);
		int first;
		logic prev;
		first = -1;
		p = 0;
		@(posedge core_clk);
		#1;
		prev = ref8kClock;
		for (int n = 0; n < 200 && p == 0; n++)
		begin
			@(posedge core_clk);
			if (dbl && n % 2 == 1)
				pins[0] <= ~pins[0];
			#1;
			if (ref8kClock === 1'b1 && prev === 1'b0)
			begin
				if (first >= 0)
					p = n - first;
				first = n;
			end
			prev = ref8kClock;
		end
	endtask
	// one-cycle pulse on a reference pin every SQ_PERIOD cycles; the last period is
	// judged by its level just after the pulse and by its count of high cycles
	task automatic square_run(input int pin, input logic lvl);
		int high;
		high = 0;
		for (int n = 0; n < 4 * SQ_PERIOD; n++)
		begin
			@(posedge core_clk);
			pins[pin] <= (n % SQ_PERIOD == 0);
			#1;
			if (n >= 3 * SQ_PERIOD && ref8kClock === 1'b1)
				high++;
			if (n == 3 * SQ_PERIOD + 6)
				chk("sq_level", 16'(lvl), 16'(ref8kClock));
		end
		chk("sq_duty", 16'(SQ_PERIOD / 2), 16'(high));
	endtask
	function automatic logic [15:0] flagOf(input int i);
		return 16'h8000 | (16'h0002 << i);
	endfunction
	function automatic logic [15:0] enOf(input int i);
		return (i < 2) ? 16'h0082 : (i < 4) ? 16'h0088 : (i == 4) ? 16'h00a0 : 16'h00c0;
	endfunction
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// hang guard, far above the run length
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			bad_count++;
			results();
		end
	end
	initial
	begin
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		idle(1);
		chk("free_run_output", 16'h0001, freeRunOutput);
		rdchk("ctrl", ADDR_CTRL, 16'h0000);
		rdchk("stat", ADDR_STAT, 16'h0000);
		rdchk("mcg", ADDR_MCG, 16'h00c0);
		rdchk("unmapped", 16'h6084, 16'h0000);
		$display("done reset");
		repeat (4)
		begin
			d = 16'($random(seed));
			wr(ADDR_CTRL, d);
			chk("rx_en", d[7], timingCellRxEn);
			rdchk("ctrl", ADDR_CTRL, d & 16'h00ff);
		end
		for (int i = 0; i < 6; i++)
		begin
			wr(ADDR_CTRL, enOf(i));
			pulse(6'h01 << i);
			idle(3);
			chk("service", 16'h0001, chipTimingService);
			wr(ADDR_CTRL, 16'h0080);
			idle(3);
			chk("masked", 16'h0000, chipTimingService);
			rdchk("flag", ADDR_STAT, flagOf(i));
			wr(ADDR_STAT, 16'h0000);
			rdchk("kept", ADDR_STAT, flagOf(i));
			wr(ADDR_STAT, flagOf(i));
			rdchk("cleared", ADDR_STAT, 16'h0000);
			@(posedge core_clk);
			evt <= 6'h00;
		end
		wr(ADDR_CTRL, 16'h0020);
		pulse(6'h10);
		rdchk("loss_off", ADDR_STAT, 16'h0000);
		// clear and a fresh event on one edge
		pulse(6'h01);
		@(posedge core_clk);
		regAddr <= ADDR_STAT;
		regWrData <= 16'h0002;
		regWrEn <= 1'b1;
		evt <= 6'h01;
		@(posedge core_clk);
		regWrEn <= 1'b0;
		evt <= 6'h00;
		rdchk("set_wins", ADDR_STAT, flagOf(0));
		@(posedge core_clk);
		flagTestForce <= 1'b1;
		rdchk("forced", ADDR_STAT, 16'h807f);
		@(posedge core_clk);
		flagTestForce <= 1'b0;
		wr(ADDR_STAT, 16'h007f);
		$display("done flags");
		@(posedge core_clk);
		for (int k = 0; k < 3; k++)
			liveCount[k] <= 16'($random(seed));
		#1 snap = liveCount;
		wr(ADDR_CTRL, 16'h0004);
		@(posedge core_clk);
		liveCount <= ~snap;
		wr(ADDR_CTRL, 16'h0000);
		for (int k = 0; k < 3; k++)
		begin
			rdchk("count", ADDR_CNT0 + 16'(2 * k), snap[k]);
			chk("held", snap[k], heldCount[k]);
		end
		for (int s = 1; s < 4; s++)
		begin
			wr(ADDR_MCG, 16'h00c0 | 16'(s));
			repeat (4)
			begin
				@(posedge core_clk);
				pins <= 4'($random(seed));
				idle(6);
				chk("ref", pins[s], ref8kClock);
			end
		end
		// stalled external pin must trip the failure watchdog; the divider runs a
		// while first so a watchdog count left from the random pins cannot fire late
		wr(ADDR_MCG, 16'h00c0);
		idle(12);
		wr(ADDR_STAT, 16'h007f);
		wr(ADDR_MCG, 16'h08c3);
		@(posedge core_clk);
		pins <= 4'h0;
		idle(3);
		chk("fr_wait", 16'h0000, freeRunOutput);
		idle(LIMIT + 20);
		rdchk("ref_fail", ADDR_STAT, 16'h8001);
		chk("fr_fail", 16'h0001, freeRunOutput);
		wr(ADDR_CTRL, 16'h0001);
		idle(3);
		chk("svc_fail", 16'h0001, chipTimingService);
		wr(ADDR_MCG, 16'h10c0);
		idle(3);
		chk("fr_low", 16'h0000, freeRunOutput);
		wr(ADDR_STAT, 16'h0001);
		idle(LIMIT + 20);
		rdchk("div_live", ADDR_STAT, 16'h0000);
		$display("done reference");
		@(posedge core_clk);
		divVal <= 14'($random(seed)) & 14'h0007;
		ref_period(1'b0, refPeriod);
		chk("div_ratio", 16'(divVal + 14'h0002), 16'(refPeriod));
		wr(ADDR_MCG, 16'h10c4);
		ref_period(1'b1, refPeriod);
		chk("dbl_ratio", 16'(4 * (divVal + 14'h0002)), 16'(refPeriod));
		wr(ADDR_MCG, 16'h1012);
		square_run(2, 1'b1);
		wr(ADDR_MCG, 16'h100b);
		square_run(3, 1'b0);
		$display("done squaring");
		results();
	end
endmodule
